// [weighted_fuzzy_rule_eval_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wre_regs.svh"
module weighted_fuzzy_rule_eval_bench;
    typedef struct packed {
        logic wen;
        logic [7:0] inA;
        logic [7:0] inB;
        logic [7:0] wgt;
        logic [7:0] pre;
    } wre_row_t;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [15:0] regWData = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic irqPending = 1'b0;
    logic [15:0] regRData;
    wre_pkg::wre_mem_req_t memReq;
    logic [15:0] memRData;
    logic irqTaken;
    logic done;
    logic busy;
    int error_cnt = 0;
    int cmp_count = 0;
    int tick = 0;
    wre_core i_wre_core (.clock(clock), .nrst(nrst), .regAddr(regAddr), .regWData(regWData),
        .regWr(regWr), .regRd(regRd), .regRData(regRData), .memReq(memReq),
        .memRData(memRData), .irqPending(irqPending), .irqTaken(irqTaken), .done(done),
        .busy(busy));
    wre_mem_model i_wre_mem_model (.clock(clock), .memReq(memReq), .memRData(memRData));
    always #25 clock = ~clock;
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        tick <= tick + 1;
        if (tick == 20000) begin
            error_cnt = error_cnt + 1;
            $display("BAD at %0t: run hung", $time);
            end_sim();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD at %0t: %s saw %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regWData <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp, input string what);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1;
        check(regRData, exp, what);
    endtask
    task automatic put_word(input logic [15:0] a, input logic [15:0] w);
        i_wre_mem_model.mem[a] = w[15:8];
        i_wre_mem_model.mem[a + 16'h0001] = w[7:0];
    endtask
    task automatic setup(input logic [15:0] list, input logic wen);
        reg_wr(`WRE_R_RULE, list);
        reg_wr(`WRE_R_WGT, 16'h0400);
        reg_wr(`WRE_R_ACC, 16'h00FF);
        reg_wr(`WRE_R_FLAGS, {14'h0000, wen, 1'b0});
        reg_wr(`WRE_R_PC, 16'h1000);
    endtask
    task automatic wait_evt(input logic irq, output int cyc);
        cyc = 0;
        while (cyc < 300) begin
            @(posedge clock);
            cyc++;
            #1;
            if ((irq ? irqTaken : done) === 1'b1) break;
        end
    endtask
    wre_row_t rows [5];
    logic [15:0] lst [8];
    wre_row_t r;
    logic [7:0] m;
    logic [7:0] t;
    logic [15:0] p;
    int cyc;
    initial begin
        rows = '{'{1'b0, 8'h40, 8'h80, 8'h33, 8'h00}, '{1'b0, 8'h90, 8'h30, 8'h11, 8'h50},
            '{1'b1, 8'hC0, 8'hFF, 8'h7F, 8'h00}, '{1'b1, 8'hFF, 8'hFF, 8'hFF, 8'h00},
            '{1'b1, 8'h80, 8'h80, 8'h00, 8'h10}};
        lst = '{16'h0200, 16'hFFFE, 16'h0300, 16'hFFFE, 16'h0201, 16'hFFFE, 16'h0301, 16'hFFFF};
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        put_word(16'h0100, 16'h0200);
        put_word(16'h0102, 16'h0201);
        put_word(16'h0104, `WRE_SEP_WORD);
        put_word(16'h0106, 16'h0300);
        put_word(16'h0108, `WRE_END_WORD);
        for (int i = 0; i < 5; i++) begin
            r = rows[i];
            i_wre_mem_model.mem[16'h0200] = r.inA;
            i_wre_mem_model.mem[16'h0201] = r.inB;
            i_wre_mem_model.mem[16'h0300] = r.pre;
            i_wre_mem_model.mem[16'h0400] = r.wgt;
            m = (r.inA < r.inB) ? r.inA : r.inB;
            p = {8'h00, m} * ({8'h00, r.wgt} + 16'h0001);
            t = r.wen ? p[15:8] : m;
            setup(16'h0100, r.wen);
            reg_wr(`WRE_R_CTRL, 16'h0001);
            #1;
            check({15'h0000, busy}, 16'h0001, "busy");
            wait_evt(1'b0, cyc);
            check(16'(cyc), r.wen ? 16'h0014 : 16'h0012, "cycles");
            p = {8'h00, (t > r.pre) ? t : r.pre};
            check({8'h00, i_wre_mem_model.mem[16'h0300]}, p, "output");
            rd_chk(`WRE_R_ACC, {8'h00, t}, "acc");
            rd_chk(`WRE_R_RULE, 16'h010A, "rule ptr");
            rd_chk(`WRE_R_WGT, 16'h0400 + {15'h0000, r.wen}, "wgt ptr");
            rd_chk(`WRE_R_FLAGS, {14'h0000, r.wen, 1'b1}, "flags");
            rd_chk(`WRE_R_PC, 16'h1002, "pc");
            $display("row %0d done", i);
        end
        for (int k = 0; k < 8; k++) put_word(16'h0120 + 16'(2 * k), lst[k]);
        i_wre_mem_model.mem[16'h0200] = 8'h20;
        i_wre_mem_model.mem[16'h0201] = 8'h90;
        put_word(16'h0300, 16'h0000);
        put_word(16'h0400, 16'hFF7F);
        setup(16'h0120, 1'b1);
        reg_wr(`WRE_R_CTRL, 16'h0001);
        wait_evt(1'b0, cyc);
        check(16'(cyc), 16'h001F, "two rule cycles");
        check({8'h00, i_wre_mem_model.mem[16'h0300]}, 16'h0020, "first out");
        check({8'h00, i_wre_mem_model.mem[16'h0301]}, 16'h0048, "second out");
        rd_chk(`WRE_R_WGT, 16'h0402, "wgt ptr two");
        rd_chk(`WRE_R_RULE, 16'h0130, "rule ptr two");
        $display("two rule test done");
        i_wre_mem_model.mem[16'h0200] = 8'h40;
        i_wre_mem_model.mem[16'h0300] = 8'h00;
        setup(16'h0100, 1'b0);
        reg_wr(`WRE_R_CTRL, 16'h0001);
        irqPending <= 1'b1;
        wait_evt(1'b1, cyc);
        @(posedge clock);
        irqPending <= 1'b0;
        rd_chk(`WRE_R_CTRL, 16'h0002, "interrupted");
        rd_chk(`WRE_R_PC, 16'h1000, "pc held");
        rd_chk(`WRE_R_RULE, 16'h0100, "rule refetch");
        reg_wr(`WRE_R_CTRL, 16'h0003);
        reg_wr(`WRE_R_RULE, 16'h0000);
        wait_evt(1'b0, cyc);
        check({8'h00, i_wre_mem_model.mem[16'h0300]}, 16'h0040, "resumed out");
        rd_chk(`WRE_R_RULE, 16'h010A, "busy write");
        rd_chk(`WRE_R_CTRL, 16'h0000, "ctrl clear");
        $display("interrupt test done");
        put_word(16'h010A, `WRE_END_WORD);
        reg_wr(`WRE_R_CTRL, 16'h0001);
        repeat (4) @(posedge clock);
        nrst <= 1'b0;
        #1;
        check({11'h000, irqTaken, memReq.wr, busy, done, memReq.rd}, 16'h0000, "reset outs");
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        reg_wr(3'h7, 16'hFFFF);
        for (int j = 0; j < 8; j++) rd_chk(3'(j), (j == 3) ? 16'h00FF : 16'h0000, "reset reg");
        $display("reset test done");
        end_sim();
    end
endmodule
`default_nettype wire

// [wre_core.sv]
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "wre_regs.svh"
module wre_core (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Register port
    input wire logic [2:0] regAddr,
    input wire logic [15:0] regWData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRData,
    // Memory bus
    output wre_pkg::wre_mem_req_t memReq,
    input wire logic [15:0] memRData,
    // Interrupt handshake and status
    input wire logic irqPending,
    output logic irqTaken,
    output logic done,
    output logic busy
);
    wre_pkg::wre_state_t st_reg, st_next;
    wre_pkg::wre_mem_req_t req_next;
    logic [15:0] rule_reg, rule_next, wgt_reg, wgt_next, pc_reg, pc_next;
    logic [15:0] hold_reg, hold_next, cur_reg, cur_next, lat_reg;
    logic [15:0] prod_reg, prod_next;
    logic [7:0] acc_reg, acc_next;
    logic phase_reg, phase_next, wen_reg, wen_next;
    logic sep_reg, sep_next, end_reg, end_next, intd_reg, intd_next;
    logic [15:0] rdMux;

    wire idle = (st_reg == wre_pkg::S_IDLE);
    wire wrCtrl = regWr && regAddr == `WRE_R_CTRL;
    wire wrRule = regWr && idle && regAddr == `WRE_R_RULE;
    wire wrWgt = regWr && idle && regAddr == `WRE_R_WGT;
    wire wrAcc = regWr && idle && regAddr == `WRE_R_ACC;
    wire wrFlags = regWr && idle && regAddr == `WRE_R_FLAGS;
    wire wrPc = regWr && idle && regAddr == `WRE_R_PC;
    wire go = wrCtrl && idle && regWData[`WRE_B_GO];
    wire intdClr = wrCtrl && regWData[`WRE_B_INTD];
    wire wordSep = (lat_reg == `WRE_SEP_WORD);
    wire wordEnd = (lat_reg == `WRE_END_WORD);
    wire smaller = (lat_reg[7:0] < acc_reg);
    wire larger = (acc_reg > lat_reg[7:0]);
    // Weight plus one, product high byte
    wire [8:0] wPlus = {1'b0, lat_reg[7:0]} + 9'h001;
    wire [16:0] prodFull = {9'h000, acc_reg} * {8'h00, wPlus};
    wire takeWeight = wordSep && !phase_reg && wen_reg;

    always_comb begin
        st_next = st_reg;
        req_next = '0;
        rule_next = wrRule ? regWData : rule_reg;
        wgt_next = wrWgt ? regWData : wgt_reg;
        pc_next = wrPc ? regWData : pc_reg;
        acc_next = wrAcc ? regWData[7:0] : acc_reg;
        phase_next = wrFlags ? regWData[`WRE_B_PHASE] : phase_reg;
        wen_next = wrFlags ? regWData[`WRE_B_WEN] : wen_reg;
        hold_next = hold_reg;
        cur_next = cur_reg;
        prod_next = prod_reg;
        sep_next = sep_reg;
        end_next = end_reg;
        intd_next = intd_reg;
        if (intdClr) begin
            intd_next = 1'b0;
        end
        case (st_reg)
            wre_pkg::S_IDLE: begin
                if (go) begin
                    st_next = wre_pkg::S_FETCH;
                end
            end
            wre_pkg::S_FETCH: begin
                req_next.addr = rule_reg;
                req_next.rd = 1'b1;
                rule_next = rule_reg + `WRE_WORD_STEP;
                st_next = wre_pkg::S_WAIT;
            end
            wre_pkg::S_WAIT: begin
                st_next = wre_pkg::S_EVAL;
            end
            wre_pkg::S_EVAL: begin
                if (irqPending) begin
                    st_next = wre_pkg::S_INT5;
                end else begin
                    cur_next = lat_reg;
                    sep_next = wordSep;
                    end_next = wordEnd;
                    st_next = wre_pkg::S_STEP;
                    if (wordSep) begin
                        phase_next = !phase_reg;
                        if (phase_reg) begin
                            acc_next = `WRE_ACC_INIT;
                        end
                        if (takeWeight) begin
                            req_next.addr = wgt_reg;
                            req_next.rd = 1'b1;
                            req_next.byteSel = 1'b1;
                            st_next = wre_pkg::S_WGT5;
                        end
                    end else if (!wordEnd) begin
                        req_next.addr = lat_reg;
                        req_next.rd = 1'b1;
                        req_next.byteSel = 1'b1;
                    end
                end
            end
            wre_pkg::S_STEP: begin
                if (!end_reg) begin
                    req_next.addr = rule_reg;
                    req_next.rd = 1'b1;
                    rule_next = rule_reg + `WRE_WORD_STEP;
                end
                st_next = wre_pkg::S_APPLY;
            end
            wre_pkg::S_APPLY: begin
                if (!sep_reg && !end_reg) begin
                    if (!phase_reg && smaller) begin
                        acc_next = lat_reg[7:0];
                    end
                    if (phase_reg && larger) begin
                        req_next.addr = cur_reg;
                        req_next.wdata = {8'h00, acc_reg};
                        req_next.wr = 1'b1;
                        req_next.byteSel = 1'b1;
                    end
                end
                st_next = end_reg ? wre_pkg::S_DONE : wre_pkg::S_EVAL;
            end
            wre_pkg::S_WGT5: begin
                hold_next = rule_reg;
                rule_next = rule_reg + `WRE_WORD_STEP;
                st_next = wre_pkg::S_WGT6;
            end
            wre_pkg::S_WGT6: begin
                prod_next = prodFull[15:0];
                st_next = wre_pkg::S_WGT7;
            end
            wre_pkg::S_WGT7: begin
                req_next.addr = hold_reg;
                req_next.rd = 1'b1;
                st_next = wre_pkg::S_WGT8;
            end
            wre_pkg::S_WGT8: begin
                acc_next = prod_reg[15:8];
                wgt_next = wgt_reg + `WRE_WGT_STEP;
                st_next = wre_pkg::S_EVAL;
            end
            wre_pkg::S_DONE: begin
                pc_next = pc_reg + `WRE_OP_LEN;
                st_next = wre_pkg::S_IDLE;
            end
            wre_pkg::S_INT5: begin
                st_next = wre_pkg::S_INT6;
            end
            wre_pkg::S_INT6: begin
                // Back up to refetch current word
                rule_next = rule_reg - `WRE_WORD_STEP;
                intd_next = 1'b1;
                st_next = wre_pkg::S_IDLE;
            end
            default: begin
                st_next = wre_pkg::S_IDLE;
            end
        endcase
    end

    always_comb begin
        case (regAddr)
            `WRE_R_CTRL: rdMux = {14'h0000, intd_reg, !idle};
            `WRE_R_RULE: rdMux = rule_reg;
            `WRE_R_WGT: rdMux = wgt_reg;
            `WRE_R_ACC: rdMux = {8'h00, acc_reg};
            `WRE_R_FLAGS: rdMux = {14'h0000, wen_reg, phase_reg};
            `WRE_R_PC: rdMux = pc_reg;
            default: rdMux = 16'h0000;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_reg <= wre_pkg::S_IDLE;
            memReq <= '0;
            rule_reg <= 16'h0000;
            wgt_reg <= 16'h0000;
            pc_reg <= 16'h0000;
            acc_reg <= `WRE_ACC_INIT;
            phase_reg <= 1'b0;
            wen_reg <= 1'b0;
            intd_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            memReq <= req_next;
            rule_reg <= rule_next;
            wgt_reg <= wgt_next;
            pc_reg <= pc_next;
            acc_reg <= acc_next;
            phase_reg <= phase_next;
            wen_reg <= wen_next;
            intd_reg <= intd_next;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hold_reg <= 16'h0000;
            cur_reg <= 16'h0000;
            prod_reg <= 16'h0000;
            lat_reg <= 16'h0000;
            sep_reg <= 1'b0;
            end_reg <= 1'b0;
        end else begin
            hold_reg <= hold_next;
            cur_reg <= cur_next;
            prod_reg <= prod_next;
            sep_reg <= sep_next;
            end_reg <= end_next;
            if (memReq.rd) begin
                lat_reg <= memRData;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            regRData <= 16'h0000;
            irqTaken <= 1'b0;
            done <= 1'b0;
            busy <= 1'b0;
        end else begin
            regRData <= regRd ? rdMux : 16'h0000;
            irqTaken <= (st_reg == wre_pkg::S_INT6);
            done <= (st_reg == wre_pkg::S_DONE);
            busy <= (st_next != wre_pkg::S_IDLE);
        end
    end

    wire evalGo = (st_reg == wre_pkg::S_EVAL) && !irqPending;
    sequence seqWeightPass;
        st_reg == wre_pkg::S_WGT5 ##1 st_reg == wre_pkg::S_WGT6 ##1
        st_reg == wre_pkg::S_WGT7 ##1 st_reg == wre_pkg::S_WGT8 ##1
        st_reg == wre_pkg::S_EVAL;
    endsequence
    sequence seqPlainPass;
        st_reg == wre_pkg::S_STEP ##1 st_reg == wre_pkg::S_APPLY;
    endsequence

    AST_WEIGHT_PASS: assert property (@(posedge clock) disable iff (!nrst)
        evalGo && takeWeight |=> seqWeightPass)
        else $error("weighting pass not five cycles");
    AST_PLAIN_PASS: assert property (@(posedge clock) disable iff (!nrst)
        evalGo && !takeWeight |=> seqPlainPass)
        else $error("plain pass not three cycles");
    AST_RELOAD: assert property (@(posedge clock) disable iff (!nrst)
        evalGo && wordSep && phase_reg |=> acc_reg == `WRE_ACC_INIT && !phase_reg)
        else $error("accumulator not reloaded on separator");
    AST_TOGGLE: assert property (@(posedge clock) disable iff (!nrst)
        evalGo && wordSep |=> phase_reg != $past(phase_reg))
        else $error("phase not toggled");
    AST_WEN_FIXED: assert property (@(posedge clock) disable iff (!nrst)
        !idle |=> $stable(wen_reg))
        else $error("weight enable changed while running");
    AST_MIN: assert property (@(posedge clock) disable iff (!nrst)
        st_reg == wre_pkg::S_APPLY && !sep_reg && !end_reg && !phase_reg && smaller
        |=> acc_reg == $past(lat_reg[7:0]))
        else $error("min not taken");
    AST_MAX: assert property (@(posedge clock) disable iff (!nrst)
        st_reg == wre_pkg::S_APPLY && !sep_reg && !end_reg && phase_reg
        |=> memReq.wr == $past(larger) && (!memReq.wr
        || (memReq.wdata[7:0] == $past(acc_reg) && memReq.addr == $past(cur_reg))))
        else $error("max write wrong");
    AST_END_NOFETCH: assert property (@(posedge clock) disable iff (!nrst)
        evalGo && wordEnd |=> ##1 !memReq.rd ##1 st_reg == wre_pkg::S_DONE)
        else $error("fetch after end marker");
    AST_STEP: assert property (@(posedge clock) disable iff (!nrst)
        st_reg == wre_pkg::S_STEP && !end_reg |=> rule_reg == $past(rule_reg) + `WRE_WORD_STEP)
        else $error("rule pointer not stepped");
    AST_MUL: assert property (@(posedge clock) disable iff (!nrst)
        st_reg == wre_pkg::S_WGT8 |=> acc_reg == $past(prod_reg[15:8])
        && wgt_reg == $past(wgt_reg) + `WRE_WGT_STEP)
        else $error("weighted value wrong");
    AST_PC_END: assert property (@(posedge clock) disable iff (!nrst)
        st_reg == wre_pkg::S_DONE |=> pc_reg == $past(pc_reg) + `WRE_OP_LEN && done)
        else $error("program counter not advanced");
    AST_INT_RESUME: assert property (@(posedge clock) disable iff (!nrst)
        st_reg == wre_pkg::S_EVAL && irqPending |=> ##1 irqTaken == 1'b0 ##1
        irqTaken && $stable(pc_reg))
        else $error("interrupt exit wrong");
endmodule
`default_nettype wire

// [wre_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module wre_mem_model (
    // Clock
    input wire logic clock,
    // Bus from the block
    input wire wre_pkg::wre_mem_req_t memReq,
    output logic [15:0] memRData
);
    logic [7:0] mem [0:65535];
    logic [15:0] noise = 16'hA55A;
    logic [15:0] wordData;
    logic [15:0] byteData;
    assign wordData = {mem[memReq.addr], mem[memReq.addr + 16'h0001]};
    assign byteData = {~noise[15:8], mem[memReq.addr]};
    // Idle bus shows a changing pattern
    assign memRData = !memReq.rd ? noise : (memReq.byteSel ? byteData : wordData);
    always @(posedge clock) begin
        noise <= ~noise;
        if (memReq.wr && memReq.byteSel) begin
            mem[memReq.addr] <= memReq.wdata[7:0];
        end else if (memReq.wr) begin
            mem[memReq.addr] <= memReq.wdata[15:8];
            mem[memReq.addr + 16'h0001] <= memReq.wdata[7:0];
        end
    end
endmodule
`default_nettype wire

// [wre_pkg.sv]
package wre_pkg;
    typedef enum logic [3:0] {
        S_IDLE, S_FETCH, S_WAIT, S_EVAL, S_STEP, S_APPLY,
        S_WGT5, S_WGT6, S_WGT7, S_WGT8, S_DONE, S_INT5, S_INT6
    } wre_state_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic rd;
        logic wr;
        logic byteSel;
    } wre_mem_req_t;
endpackage

// [wre_regs.svh]
`ifndef WRE_REGS_SVH
`define WRE_REGS_SVH
`define WRE_SEP_WORD 16'hFFFE
`define WRE_END_WORD 16'hFFFF
`define WRE_ACC_INIT 8'hFF
`define WRE_WORD_STEP 16'h0002
`define WRE_WGT_STEP 16'h0001
`define WRE_OP_LEN 16'h0002
`define WRE_R_CTRL 3'h0
`define WRE_R_RULE 3'h1
`define WRE_R_WGT 3'h2
`define WRE_R_ACC 3'h3
`define WRE_R_FLAGS 3'h4
`define WRE_R_PC 3'h5
`define WRE_B_GO 0
`define WRE_B_BUSY 0
`define WRE_B_INTD 1
`define WRE_B_PHASE 0
`define WRE_B_WEN 1
`endif
